/* logic/pcc_top.sv */
`timescale 1ns/1ps
module pcc_top
   import pcc_pkg::*;
#(
   parameter int MAX_PAYLOAD_BYTES = 512,
   parameter logic [24:0] DEVCAP_BITS = 25'h000_0000,
   parameter logic RELAXED_ORDER = 1'b1,
   parameter logic [5:0] MAX_LINK_WIDTH = 6'h04,
   parameter logic [4:0] DEVCAP2_BITS = 5'h00,
   parameter logic MSI_ENABLE = 1'b1,
   parameter logic [2:0] MSI_REQ_LOG2 = 3'h0,
   parameter logic AER_ENABLE = 1'b1,
   parameter int BLOCK_RAM_BYTES = 1024
)
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Interrupt
   output logic irq,
   // User application side
   output logic msi_enable,
   output logic [2:0] msi_granted_count
);
   // -----------------------------
   // Derived build constants
   // -----------------------------
   // Payload code: 128B gives 0, each doubling adds one
   localparam logic [2:0] PAYLOAD_CODE =
      3'($clog2(MAX_PAYLOAD_BYTES) - $clog2(PAYLOAD_BASE));
   // Small payloads still get the smallest retry buffer
   localparam int RETRY_BYTES =
      (MAX_PAYLOAD_BYTES < MIN_RETRY_BYTES) ? MIN_RETRY_BYTES : MAX_PAYLOAD_BYTES;
   localparam int RETRY_BLOCKS = (RETRY_BYTES + BLOCK_RAM_BYTES - 1) / BLOCK_RAM_BYTES;
   // Read-only words, fixed after elaboration
   localparam logic [31:0] DEVCAP_WORD = {4'h0, DEVCAP_BITS, PAYLOAD_CODE};
   localparam logic [31:0] DEVCTL_WORD = 32'(RELAXED_ORDER) << RLX_BIT;
   localparam logic [31:0] LINKCAP_WORD = 32'(MAX_LINK_WIDTH) << LW_LSB;
   localparam logic [31:0] DEVCAP2_WORD = {27'h000_0000, DEVCAP2_BITS};
   localparam logic [31:0] AER_WORD = AER_ENABLE ?
      {12'h000, AER_VERSION, AER_CAP_ID} : 32'h0000_0000;
   localparam logic [31:0] RETRY_WORD = {16'(RETRY_BLOCKS), 16'(RETRY_BYTES)};

   // -----------------------------
   // Elaboration checks
   // -----------------------------
   generate
      if (MAX_PAYLOAD_BYTES < PAYLOAD_BASE || MAX_PAYLOAD_BYTES > 4096 ||
          (MAX_PAYLOAD_BYTES & (MAX_PAYLOAD_BYTES - 1)) != 0)
      begin : g_bad_payload
         $error("max payload must be a power of two, 128 to 4096");
      end
      if (MSI_REQ_LOG2 > 3'h5)
      begin : g_bad_msi
         $error("at most 32 messages may be requested");
      end
      if (BLOCK_RAM_BYTES < 1)
      begin : g_bad_ram
         $error("block ram size must be positive");
      end
   endgenerate

   // -----------------------------
   // Bus slave and interrupt unit
   // -----------------------------
   pcc_reg_if reg_bus ();
   logic [NUM_EV-1:0] events;
   logic [NUM_EV-1:0] ev_status;
   logic [NUM_EV-1:0] ev_mask;

   // AHB-Lite slave, one wait state per access
   pcc_ahb_slave u_slave (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .bus(reg_bus.slave)
   );

   // Sticky events, masked onto one level
   pcc_irq u_irq (
      .hclk(hclk),
      .hresetn(hresetn),
      .event_in(events),
      .status_rd(reg_bus.rd && reg_bus.addr == OFS_STATUS),
      .mask_wr(reg_bus.wr && reg_bus.addr == OFS_MASK),
      .mask_wdata(reg_bus.wdata[NUM_EV-1:0]),
      .status(ev_status),
      .mask(ev_mask),
      .irq(irq)
   );

   // -----------------------------
   // Writable MSI control state
   // -----------------------------
   typedef struct packed {
      logic msi_en;
      logic [2:0] grant;
   } pcc_cfg_state_type;
   pcc_cfg_state_type s;
   pcc_cfg_state_type next_s;

   // Host may grant no more than was requested
   function automatic logic [2:0] clamp_grant(input logic [2:0] req);
      clamp_grant = (req > MSI_REQ_LOG2) ? MSI_REQ_LOG2 : req;
   endfunction : clamp_grant

   logic msi_wr;
   logic ro_wr;
   logic [2:0] wr_grant;
   // Write to the MSI word only counts when MSI is built in
   assign msi_wr = reg_bus.wr && reg_bus.addr == OFS_MSI && MSI_ENABLE;
   assign wr_grant = clamp_grant(reg_bus.wdata[MSI_GNT_LSB +: 3]);
   // Writes to fixed words are dropped but reported
   assign ro_wr = reg_bus.wr && (reg_bus.addr == OFS_DEVCAP ||
      reg_bus.addr == OFS_DEVCTL || reg_bus.addr == OFS_LINKCAP ||
      reg_bus.addr == OFS_DEVCAP2 || reg_bus.addr == OFS_AER ||
      reg_bus.addr == OFS_RETRY);

   // Next-state logic for MSI control
   always_comb
   begin
      next_s = s;
      if (msi_wr)
      begin
         next_s.msi_en = reg_bus.wdata[MSI_EN_BIT];
         next_s.grant = wr_grant;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign msi_enable = s.msi_en;
   assign msi_granted_count = s.grant;

   // Grant event fires only on a real change
   assign events[EV_GRANT] = msi_wr &&
      (wr_grant != s.grant || reg_bus.wdata[MSI_EN_BIT] != s.msi_en);
   assign events[EV_RO_WRITE] = ro_wr;

   // -----------------------------
   // Read multiplexer
   // -----------------------------
   logic [31:0] msi_word;
   // MSI word: id, enable, requested, granted; zero when absent
   assign msi_word = MSI_ENABLE ? ({24'h00_0000, MSI_CAP_ID} |
      (32'(s.msi_en) << MSI_EN_BIT) |
      (32'(MSI_REQ_LOG2) << MSI_REQ_LSB) |
      (32'(s.grant) << MSI_GNT_LSB)) : 32'h0000_0000;

   // Address decode; unmapped offsets read zero
   always_comb
   begin
      if (reg_bus.addr == OFS_DEVCAP)
         reg_bus.rdata = DEVCAP_WORD;
      else if (reg_bus.addr == OFS_DEVCTL)
         reg_bus.rdata = DEVCTL_WORD;
      else if (reg_bus.addr == OFS_LINKCAP)
         reg_bus.rdata = LINKCAP_WORD;
      else if (reg_bus.addr == OFS_DEVCAP2)
         reg_bus.rdata = DEVCAP2_WORD;
      else if (reg_bus.addr == OFS_MSI)
         reg_bus.rdata = msi_word;
      else if (reg_bus.addr == OFS_AER)
         reg_bus.rdata = AER_WORD;
      else if (reg_bus.addr == OFS_RETRY)
         reg_bus.rdata = RETRY_WORD;
      else if (reg_bus.addr == OFS_STATUS)
         reg_bus.rdata = 32'(ev_status);
      else if (reg_bus.addr == OFS_MASK)
         reg_bus.rdata = 32'(ev_mask);
      else
         reg_bus.rdata = 32'h0000_0000;
   end

   // -----------------------------
   // Assertions
   // -----------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_rd(logic [7:0] ofs);
      reg_bus.rd && reg_bus.addr == ofs;
   endsequence

   property p_payload;
      s_rd(OFS_DEVCAP) |=> hrdata[2:0] == PAYLOAD_CODE &&
         hrdata[2:0] == 3'($clog2(MAX_PAYLOAD_BYTES) - 7);
   endproperty
   a_payload: assert property (p_payload) else $error("payload code wrong");

   property p_retry;
      s_rd(OFS_RETRY) |=> hrdata[15:0] >= 16'(MIN_RETRY_BYTES) &&
         hrdata[15:0] >= 16'(MAX_PAYLOAD_BYTES);
   endproperty
   a_retry: assert property (p_retry) else $error("retry buffer undersized");

   property p_devcap;
      s_rd(OFS_DEVCAP) |=> hrdata[27:3] == DEVCAP_BITS && hreadyout;
   endproperty
   a_devcap: assert property (p_devcap) else $error("devcap field wrong");

   property p_relaxed;
      s_rd(OFS_DEVCTL) |=> hrdata[RLX_BIT] == RELAXED_ORDER;
   endproperty
   a_relaxed: assert property (p_relaxed) else $error("relaxed bit wrong");

   property p_width;
      s_rd(OFS_LINKCAP) |=> hrdata[LW_LSB +: 6] == MAX_LINK_WIDTH;
   endproperty
   a_width: assert property (p_width) else $error("link width wrong");

   property p_devcap2;
      s_rd(OFS_DEVCAP2) |=> hrdata[4:0] == DEVCAP2_BITS && hrdata[31:5] == 27'h0;
   endproperty
   a_devcap2: assert property (p_devcap2) else $error("devcap2 field wrong");

   property p_msi_absent;
      !MSI_ENABLE |-> msi_granted_count == 3'h0 && !msi_enable;
   endproperty
   a_msi_absent: assert property (p_msi_absent) else $error("msi present");

   sequence s_grant_wr;
      reg_bus.wr && reg_bus.addr == OFS_MSI;
   endsequence

   property p_grant;
      s_grant_wr ##0 (MSI_ENABLE == 1'b1) |=>
         msi_granted_count == clamp_grant($past(reg_bus.wdata[MSI_GNT_LSB +: 3])) &&
         msi_granted_count <= MSI_REQ_LOG2;
   endproperty
   a_grant: assert property (p_grant) else $error("granted count wrong");

   property p_aer;
      s_rd(OFS_AER) |=> hrdata[AER_VER_LSB +: 4] == (AER_ENABLE ? 4'h1 : 4'h0);
   endproperty
   a_aer: assert property (p_aer) else $error("aer version wrong");

   property p_ro_write;
      ro_wr |=> ev_status[EV_RO_WRITE] && $stable(msi_granted_count);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("fixed word write");

   property p_irq;
      |(ev_status & ev_mask) |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");

   // -----------------------------
   // Presence, access and status assertions
   // -----------------------------
   // Built-in MSI word shows its id and the fixed request
   property p_msi_id;
      s_rd(OFS_MSI) ##0 MSI_ENABLE |=> hrdata[7:0] == MSI_CAP_ID &&
         hrdata[MSI_REQ_LSB +: 3] == MSI_REQ_LOG2;
   endproperty
   a_msi_id: assert property (p_msi_id) else $error("msi word wrong");

   // Left-out MSI structure reads as nothing
   property p_msi_gone;
      s_rd(OFS_MSI) ##0 !MSI_ENABLE |=> hrdata == 32'h0000_0000;
   endproperty
   a_msi_gone: assert property (p_msi_gone) else $error("msi word present");

   // Without MSI a host write leaves no trace
   property p_msi_wr_ignored;
      s_grant_wr ##0 !MSI_ENABLE |=> !msi_enable && msi_granted_count == 3'h0 &&
         !ev_status[EV_GRANT];
   endproperty
   a_msi_wr_ignored: assert property (p_msi_wr_ignored) else $error("msi write took");

   // Built-in AER word carries its id
   property p_aer_id;
      s_rd(OFS_AER) ##0 AER_ENABLE |=> hrdata[15:0] == AER_CAP_ID;
   endproperty
   a_aer_id: assert property (p_aer_id) else $error("aer id wrong");

   // Left-out AER structure reads as nothing
   property p_aer_gone;
      s_rd(OFS_AER) ##0 !AER_ENABLE |=> hrdata == 32'h0000_0000;
   endproperty
   a_aer_gone: assert property (p_aer_gone) else $error("aer word present");

   // Flipping the MSI enable is reported to software
   property p_grant_event;
      s_grant_wr ##0 (MSI_ENABLE && reg_bus.wdata[MSI_EN_BIT] != msi_enable) |=>
         ev_status[EV_GRANT];
   endproperty
   a_grant_event: assert property (p_grant_event) else $error("grant event missing");

   // Only an MSI word write may move the control state
   property p_grant_hold;
      !(reg_bus.wr && reg_bus.addr == OFS_MSI) |=> $stable(msi_granted_count) &&
         $stable(msi_enable);
   endproperty
   a_grant_hold: assert property (p_grant_hold) else $error("msi state moved");

   // Every response is OKAY
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");

   // Writes leave zero on the read data
   property p_wr_zero;
      reg_bus.wr |=> hrdata == 32'h0000_0000;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write read data not zero");

   // Status read with no new event leaves it empty
   property p_status_clear;
      s_rd(OFS_STATUS) ##0 !(|events) |=> ev_status == '0;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");

   // Mask takes the written bits
   property p_mask_wr;
      reg_bus.wr && reg_bus.addr == OFS_MASK |=> ev_mask == $past(reg_bus.wdata[NUM_EV-1:0]);
   endproperty
   a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

   // No unmasked status, no interrupt
   property p_irq_low;
      !(|(ev_status & ev_mask)) |-> !irq;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq without cause");
endmodule : pcc_top

/* logic/pcc_pkg.sv */
// Operation
// - Advertise max payload; size retry buffer accordingly
// - 25-bit parameter fills device capabilities 27:3
// - Relaxed ordering only sets capability bit
// - Advertise configured maximum link width
// - 5-bit parameter fills device capabilities 2 4:0
// - MSI structure present only when enabled
// - Advertise requested MSIs; output granted count
// - AER capability present only when enabled
// - AER capability version fixed at one
package pcc_pkg;
   // -----------------------------
   // Register offsets (byte address)
   // -----------------------------
   localparam logic [7:0] OFS_DEVCAP = 8'h00;
   localparam logic [7:0] OFS_DEVCTL = 8'h04;
   localparam logic [7:0] OFS_LINKCAP = 8'h08;
   localparam logic [7:0] OFS_DEVCAP2 = 8'h0c;
   localparam logic [7:0] OFS_MSI = 8'h10;
   localparam logic [7:0] OFS_AER = 8'h14;
   localparam logic [7:0] OFS_RETRY = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   localparam logic [7:0] OFS_MASK = 8'h20;
   // -----------------------------
   // Field positions and constants
   // -----------------------------
   localparam int RLX_BIT = 4;
   localparam int LW_LSB = 4;
   localparam int MSI_EN_BIT = 16;
   localparam int MSI_REQ_LSB = 17;
   localparam int MSI_GNT_LSB = 20;
   localparam int AER_VER_LSB = 16;
   localparam logic [7:0] MSI_CAP_ID = 8'h05;
   localparam logic [15:0] AER_CAP_ID = 16'h0001;
   localparam logic [3:0] AER_VERSION = 4'h1;
   localparam int MIN_RETRY_BYTES = 512;
   localparam int PAYLOAD_BASE = 128;
   // Interrupt events
   localparam int EV_GRANT = 0;
   localparam int EV_RO_WRITE = 1;
   localparam int NUM_EV = 2;
   // Bus slave phases
   typedef enum logic [0:0] {PCC_IDLE = 1'b0, PCC_DATA = 1'b1} pcc_phase_type;
endpackage : pcc_pkg

/* logic/pcc_reg_if.sv */
`timescale 1ns/1ps
// Register access strobes between bus slave and register bank
interface pcc_reg_if;
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport slave (output wr, output rd, output addr, output wdata, input rdata);
   modport bank (input wr, input rd, input addr, input wdata, output rdata);
endinterface : pcc_reg_if

/* logic/pcc_ahb_slave.sv */
`timescale 1ns/1ps
module pcc_ahb_slave
   import pcc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Register strobes
   pcc_reg_if.slave bus
);
   // -----------------------------
   // State
   // -----------------------------
   typedef struct packed {
      pcc_phase_type phase;
      logic [7:0] addr;
      logic write;
      logic ready;
      logic resp;
      logic [31:0] rdata;
   } pcc_ahb_state_type;
   pcc_ahb_state_type s;
   pcc_ahb_state_type next_s;
   logic taken;
   // Only NONSEQ/SEQ with hready count; size is always a whole word
   assign taken = hsel && htrans[1] && hready;
   // Every access takes one wait state so read data leaves a flop
   always_comb
   begin
      next_s = s;
      case (s.phase)
         PCC_IDLE:
         begin
            if (taken)
            begin
               next_s.phase = PCC_DATA;
               next_s.addr = haddr[7:0];
               next_s.write = hwrite;
               next_s.ready = 1'b0;
            end
         end
         default:
         begin
            next_s.phase = PCC_IDLE;
            next_s.ready = 1'b1;
            next_s.rdata = s.write ? 32'h0000_0000 : bus.rdata;
         end
      endcase
   end
   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '{PCC_IDLE, 8'h00, 1'b0, 1'b1, 1'b0, 32'h0000_0000};
      else
         s <= next_s;
   end
   assign bus.wr = (s.phase == PCC_DATA) && s.write;
   assign bus.rd = (s.phase == PCC_DATA) && !s.write;
   assign bus.addr = s.addr;
   assign bus.wdata = hwdata;
   assign hreadyout = s.ready;
   assign hresp = s.resp;
   assign hrdata = s.rdata;
   // Taken request: one wait cycle then ready
   property p_ahb_wait;
      @(posedge hclk) disable iff (!hresetn)
      (s.phase == PCC_IDLE && taken) |=> !hreadyout ##1 (hreadyout && !hresp);
   endproperty
   a_ahb_wait: assert property (p_ahb_wait) else $error("ahb wait state wrong");
endmodule : pcc_ahb_slave

/* logic/pcc_irq.sv */
`timescale 1ns/1ps
module pcc_irq
   import pcc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Events and software access
   input wire logic [NUM_EV-1:0] event_in,
   input wire logic status_rd,
   input wire logic mask_wr,
   input wire logic [NUM_EV-1:0] mask_wdata,
   // State out
   output logic [NUM_EV-1:0] status,
   output logic [NUM_EV-1:0] mask,
   output logic irq
);
   typedef struct packed {
      logic [NUM_EV-1:0] status;
      logic [NUM_EV-1:0] mask;
      logic irq;
   } pcc_irq_state_type;
   pcc_irq_state_type s;
   pcc_irq_state_type next_s;
   // Read clears; a fresh event in the same cycle survives
   always_comb
   begin
      next_s = s;
      if (status_rd)
         next_s.status = '0;
      next_s.status = next_s.status | event_in;
      if (mask_wr)
         next_s.mask = mask_wdata;
      next_s.irq = |(next_s.status & next_s.mask);
   end
   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= next_s;
   end
   assign status = s.status;
   assign mask = s.mask;
   assign irq = s.irq;
   // Event never lost, even against a clearing read
   property p_ev_sticky;
      @(posedge hclk) disable iff (!hresetn)
      |event_in |=> (status & $past(event_in)) == $past(event_in);
   endproperty
   a_ev_sticky: assert property (p_ev_sticky) else $error("event lost");
endmodule : pcc_irq

/* test/pcc_host_model.sv */
`timescale 1ns/1ps
// ---------------------------------
// Host side register bus master
// ---------------------------------
module pcc_host_model
(
   // Clock
   input wire logic hclk,
   // Master request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // Slave answer
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   // Quiet bus from time zero
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // One whole-word transfer; called just after a rising edge
   // One transfer at a time, so the host issues in strict order
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= addr;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      // Address phase holds until ready is sampled high
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~addr;
      hwdata <= wd;
      // Data phase holds until ready is sampled high again
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      // Released data no longer shows the last value
      hwdata <= ~wd;
   endtask : xfer
endmodule : pcc_host_model

/* test/test_pcie_capability_config.sv */
`timescale 1ns/1ps
module test_pcie_capability_config;
   import pcc_pkg::*;
   // ---------------------------------
   // Settings and signals
   // ---------------------------------
   localparam logic [24:0] DEVCAP_V = 25'h155_5555;
   localparam logic [4:0] DEVCAP2_V = 5'h15;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic irq;
   logic msi_enable;
   logic [2:0] msi_granted_count;
   // Second build: no MSI, no AER, strict ordering, large payload
   logic hsel_b;
   logic [31:0] haddr_b;
   logic [1:0] htrans_b;
   logic hwrite_b;
   logic [2:0] hsize_b;
   logic [31:0] hwdata_b;
   logic hreadyout_b;
   logic hresp_b;
   logic [31:0] hrdata_b;
   logic irq_b;
   logic msi_enable_b;
   logic [2:0] msi_granted_count_b;
   // Counters
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   // Payload 256 bytes takes the 512 byte retry buffer
   pcc_top #(.MAX_PAYLOAD_BYTES(256), .DEVCAP_BITS(DEVCAP_V), .MAX_LINK_WIDTH(6'h02),
      .DEVCAP2_BITS(DEVCAP2_V), .MSI_REQ_LOG2(3'h3)) u_dut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .irq(irq), .msi_enable(msi_enable),
      .msi_granted_count(msi_granted_count));

   // Host model drives the bus
   pcc_host_model u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

   // Second build with its own host, so the left-out paths run too
   pcc_top #(.MAX_PAYLOAD_BYTES(2048), .RELAXED_ORDER(1'b0), .MSI_ENABLE(1'b0),
      .AER_ENABLE(1'b0)) u_dut_b (.hclk(hclk), .hresetn(hresetn), .hsel(hsel_b),
      .haddr(haddr_b), .htrans(htrans_b), .hwrite(hwrite_b), .hsize(hsize_b),
      .hwdata(hwdata_b), .hready(hreadyout_b), .hreadyout(hreadyout_b), .hresp(hresp_b),
      .hrdata(hrdata_b), .irq(irq_b), .msi_enable(msi_enable_b),
      .msi_granted_count(msi_granted_count_b));

   pcc_host_model u_host_b (.hclk(hclk), .hsel(hsel_b), .haddr(haddr_b),
      .htrans(htrans_b), .hwrite(hwrite_b), .hsize(hsize_b), .hwdata(hwdata_b),
      .hready(hreadyout_b), .hrdata(hrdata_b));

   // ---------------------------------
   // Tasks
   // ---------------------------------
   // Verdict and end of run
   task automatic results();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   // Compare seen against expected
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Register write; response must be OKAY
   task automatic wr(input logic [7:0] ofs, input logic [31:0] d, input logic b = 1'b0);
      logic [31:0] unused;
      if (b)
         u_host_b.xfer(1'b1, {24'h0, ofs}, d, unused);
      else
         u_host.xfer(1'b1, {24'h0, ofs}, d, unused);
      check("hresp", {31'h0, b ? hresp_b : hresp}, 32'h0);
   endtask : wr

   // Register read against an expected word
   task automatic rdchk(input string name, input logic [7:0] ofs, input logic [31:0] exp,
      input logic b = 1'b0);
      logic [31:0] d;
      if (b)
         u_host_b.xfer(1'b0, {24'h0, ofs}, 32'h0, d);
      else
         u_host.xfer(1'b0, {24'h0, ofs}, 32'h0, d);
      check("hresp", {31'h0, b ? hresp_b : hresp}, 32'h0);
      check(name, d, exp);
   endtask : rdchk

   // Settled output flags, then realign to a rising edge
   task automatic flags(input logic ir, input logic en, input logic [2:0] gc,
      input logic b = 1'b0);
      @(negedge hclk);
      check("irq", {31'h0, b ? irq_b : irq}, {31'h0, ir});
      check("msi_enable", {31'h0, b ? msi_enable_b : msi_enable}, {31'h0, en});
      check("granted", {29'h0, b ? msi_granted_count_b : msi_granted_count}, {29'h0, gc});
      @(posedge hclk);
   endtask : flags

   // Every fixed capability word
   task automatic fixed_words();
      rdchk("devcap", OFS_DEVCAP, {4'h0, DEVCAP_V, 3'h1});
      rdchk("devctl", OFS_DEVCTL, 32'h0000_0001 << RLX_BIT);
      rdchk("linkcap", OFS_LINKCAP, {22'h0, 6'h02, 4'h0});
      rdchk("devcap2", OFS_DEVCAP2, {27'h0, DEVCAP2_V});
      rdchk("aer", OFS_AER, {12'h0, AER_VERSION, AER_CAP_ID});
      rdchk("retry", OFS_RETRY, 32'h0001_0200);
      rdchk("unmapped", 8'h24, 32'h0000_0000);
   endtask : fixed_words

   // ---------------------------------
   // Clock and hang guard
   // ---------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // Whole run needs under two hundred cycles
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         results();
      end
   end

   // ---------------------------------
   // Test sequence
   // ---------------------------------
   initial
   begin
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset state
      flags(1'b0, 1'b0, 3'h0);
      rdchk("status", OFS_STATUS, 32'h0000_0000);
      rdchk("mask", OFS_MASK, 32'h0000_0000);
      $display("test reset done");
      // Fixed words and MSI word as built
      fixed_words();
      rdchk("msi", OFS_MSI, 32'h0006_0005);
      $display("test capability words done");
      // Back to back writes into fixed words change no word, only the read-only event
      for (int i = 0; i < 7; i++)
         if (i != 4)
            wr(8'(4 * i), 32'hffff_ffff);
      fixed_words();
      flags(1'b0, 1'b0, 3'h0);
      wr(OFS_MASK, 32'h0000_0002);
      flags(1'b1, 1'b0, 3'h0);
      rdchk("status", OFS_STATUS, 32'h0000_0002);
      flags(1'b0, 1'b0, 3'h0);
      rdchk("status", OFS_STATUS, 32'h0000_0000);
      $display("test read only done");
      // Host grants vectors; grant clamps to the request
      wr(OFS_MASK, 32'h0000_0001);
      wr(OFS_MSI, 32'h0021_0000);
      flags(1'b1, 1'b1, 3'h2);
      rdchk("msi", OFS_MSI, 32'h0027_0005);
      wr(OFS_MSI, 32'h0071_0000);
      flags(1'b1, 1'b1, 3'h3);
      rdchk("msi", OFS_MSI, 32'h0037_0005);
      rdchk("status", OFS_STATUS, 32'h0000_0001);
      flags(1'b0, 1'b1, 3'h3);
      rdchk("mask", OFS_MASK, 32'h0000_0001);
      $display("test msi grant done");
      // Reset in mid run returns the control state to zero
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      flags(1'b0, 1'b0, 3'h0);
      rdchk("status", OFS_STATUS, 32'h0000_0000);
      rdchk("mask", OFS_MASK, 32'h0000_0000);
      rdchk("msi", OFS_MSI, 32'h0006_0005);
      $display("test mid reset done");
      // Second build: structures left out, strict ordering, 2 KB payload
      rdchk("devcap", OFS_DEVCAP, 32'h0000_0004, 1'b1);
      rdchk("devctl", OFS_DEVCTL, 32'h0000_0000, 1'b1);
      rdchk("linkcap", OFS_LINKCAP, 32'h0000_0040, 1'b1);
      rdchk("devcap2", OFS_DEVCAP2, 32'h0000_0000, 1'b1);
      rdchk("msi", OFS_MSI, 32'h0000_0000, 1'b1);
      rdchk("aer", OFS_AER, 32'h0000_0000, 1'b1);
      rdchk("retry", OFS_RETRY, 32'h0002_0800, 1'b1);
      wr(OFS_MASK, 32'h0000_0003, 1'b1);
      wr(OFS_MSI, 32'h0071_0000, 1'b1);
      flags(1'b0, 1'b0, 3'h0, 1'b1);
      rdchk("msi", OFS_MSI, 32'h0000_0000, 1'b1);
      rdchk("status", OFS_STATUS, 32'h0000_0000, 1'b1);
      $display("test second build done");
      results();
   end
endmodule : test_pcie_capability_config
